// ===== erx_desc_model.sv
// far-side model: descriptor engine answering fetches and closing frame transfers
// assumes the control block on the same clock; own_cfg picked by the bench
`timescale 1ns/1ps
`default_nettype none
module erx_desc_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // fetch side
    input wire logic desc_req,
    input wire logic [31:0] desc_addr,
    input wire logic own_cfg,
    output logic desc_ack,
    output logic desc_own,
    output logic [31:0] desc_next,
    // transfer side
    input wire logic dma_req,
    output logic xfer_done
);
    logic [2:0] cnt_r;
    // desc_own and desc_next toggle outside an answer so a stale value never reads as valid
    always @(posedge ref_clk) begin
        desc_ack <= 1'b0;
        xfer_done <= 1'b0;
        desc_own <= ~desc_own;
        desc_next <= ~desc_next;
        if (!rstn) begin
            cnt_r <= 3'h0;
            desc_own <= 1'b0;
            desc_next <= 32'h0;
        end else begin
            if (desc_req && !desc_ack) begin
                desc_ack <= 1'b1;
                desc_own <= own_cfg;
                desc_next <= desc_addr + 32'h0000_0010;
            end
            if (cnt_r != 3'h0) begin
                cnt_r <= cnt_r - 3'h1;
                xfer_done <= (cnt_r == 3'h1);
            end else if (dma_req) begin
                cnt_r <= 3'h3;
            end
        end
    end
endmodule
`default_nettype wire

// ===== erx_opmode_ctrl.sv
// rx fifo / dma operation-mode control: register port, frame filter, threshold request,
// flow control, tx second-frame gate and rx dma start/stop process.
// assumes the fifo, mac path and descriptor engine sit outside on the same clock.
// Contract
// R1 - hw flow control follows fifo fill level only while its enable is set
// R2 - error frames dropped when error forwarding is off
// R3 - error frame already handed to read side in threshold mode is kept
// R4 - error forwarding on passes all frames except runt errors; code still drops partial-overflow and, with R6 off, undersized good frames
// R5 - partial frame hit by fifo overflow is always dropped
// R6 - undersized good frames forwarded when undersized forwarding is on
// R7 - frames under 64 bytes dropped when off, unless already handed; code keeps error frames under 64 bytes while error forwarding is on
// R8 - request dma when fifo frame bytes exceed threshold, or frame complete
// R9 - threshold codes 00,01,10,11 select 64,32,96,128 bytes
// R10 - software avoids code 11 with a 128-byte fifo
// R11 - threshold only used while store-and-forward is off
// R12 - second-frame bit lets tx dma start before first status returns
// R13 - start enters running and fetches from base or retained position
// R14 - no owned descriptor suspends reception and sets status bit 7
// R15 - software sets list base before start, starts only when stopped
// R16 - stop takes effect after current frame; next position kept
// R17 - stop honoured only while running or suspended
// R18 - reserved bits 5 and 0 ignore writes and read zero
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module erx_opmode_ctrl #(
    parameter int FILL_W = 12,
    parameter logic [FILL_W-1:0] FC_ON_LVL = 12'hC00,
    parameter logic [FILL_W-1:0] FC_OFF_LVL = 12'h800
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // receive fifo side
    input wire logic [FILL_W-1:0] fifo_fill,
    input wire logic rx_sof,
    input wire logic [15:0] rx_bytes,
    input wire logic rx_full_frame,
    input wire logic rx_eof,
    input wire erx_pkg::erx_frame_s rx_frame,
    output logic frame_drop,
    output logic frame_keep,
    output logic flow_ctrl,
    output logic dma_req,
    // descriptor engine
    output logic desc_req,
    output logic [31:0] desc_addr,
    input wire logic desc_ack,
    input wire logic desc_own,
    input wire logic [31:0] desc_next,
    input wire logic desc_poll,
    input wire logic xfer_done,
    output logic rx_running,
    // transmit side
    input wire logic tx_frame_ready,
    input wire logic tx_status_pending,
    output logic tx_start_ok
);
    import erx_pkg::*;

    erx_state_s s_r;
    erx_state_s s_nxt;
    logic sr;
    logic rx_store_forward;
    logic fef;
    logic fwd_undersized_good;
    logic [15:0] thr;
    logic over_thr;
    logic err;
    logic dma_act;

    // --------------------------------------------------------------
    // decode of control fields
    // --------------------------------------------------------------
    assign sr = s_r.opmode[B_SR];
    assign rx_store_forward = s_r.opmode[B_RSF];
    assign fef = s_r.opmode[B_FEF];
    assign fwd_undersized_good = s_r.opmode[B_FUF];

    always_comb begin
        case (s_r.opmode[B_RTC+:2]) // see R9
            2'b00: thr = THR_C0;
            2'b01: thr = THR_C1;
            2'b10: thr = THR_C2;
            default: thr = THR_C3;
        endcase
    end

    // store-and-forward ignores the threshold entirely
    assign over_thr = !rx_store_forward && (rx_bytes > thr); // see R11
    assign dma_act = (s_r.rxst == RX_RUNNING) || (s_r.rxst == RX_XFER);
    assign err = rx_frame.crc_err | rx_frame.collision | rx_frame.rx_err |
                 rx_frame.giant | rx_frame.watchdog | rx_frame.overflow;

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign dma_req = dma_act && (rx_full_frame || over_thr); // see R8
    assign tx_start_ok = tx_frame_ready &&
                         (!tx_status_pending || s_r.opmode[B_OSF]); // see R12
    assign desc_req = (s_r.rxst == RX_FETCH);
    assign desc_addr = s_r.curpos;
    assign rx_running = dma_act;
    assign reg_rdata = s_r.rdata;
    assign frame_drop = s_r.drop;
    assign frame_keep = s_r.keep;
    assign flow_ctrl = s_r.fc_on;
    assign irq = |(s_r.status & s_r.mask);

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.drop = 1'b0;
        s_nxt.keep = 1'b0;
        s_nxt.rdata = WORD_RST;
        if (reg_wr) begin
            if (reg_addr == OFS_OPMODE) begin
                s_nxt.opmode = reg_wdata & OPMODE_WMASK; // see R18
            end else if (reg_addr == OFS_MASK) begin
                s_nxt.mask = reg_wdata & STATUS_BITS;
            end else if (reg_addr == OFS_RXBASE) begin
                s_nxt.rxbase = reg_wdata;
                s_nxt.fresh = 1'b1;
            end
        end
        if (reg_rd) begin
            if (reg_addr == OFS_OPMODE) begin
                s_nxt.rdata = s_r.opmode;
            end else if (reg_addr == OFS_STATUS) begin
                s_nxt.rdata = s_r.status;
                s_nxt.status = WORD_RST;
            end else if (reg_addr == OFS_MASK) begin
                s_nxt.rdata = s_r.mask;
            end else if (reg_addr == OFS_RXBASE) begin
                s_nxt.rdata = s_r.rxbase;
            end else if (reg_addr == OFS_CURPOS) begin
                s_nxt.rdata = s_r.curpos;
            end
        end
        // hysteresis keeps pause frames from chattering at one level
        if (!s_r.opmode[B_HWFC]) begin
            s_nxt.fc_on = 1'b0; // see R1
        end else if (fifo_fill >= FC_ON_LVL) begin
            s_nxt.fc_on = 1'b1; // see R1
        end else if (fifo_fill < FC_OFF_LVL) begin
            s_nxt.fc_on = 1'b0;
        end
        // start pointer counts as handed once the threshold request fired
        if (rx_sof) begin
            s_nxt.handed = 1'b0;
        end else if (dma_act && over_thr) begin
            s_nxt.handed = 1'b1;
        end
        if (rx_eof) begin
            if (rx_frame.part_ovf) begin
                s_nxt.drop = 1'b1; // see R5
            end else if (s_r.handed) begin
                s_nxt.keep = 1'b1; // see R3, R7
            end else if (rx_frame.runt) begin
                s_nxt.drop = 1'b1; // see R4
            end else if (err) begin
                s_nxt.keep = fef; // see R4
                s_nxt.drop = !fef; // see R2
            end else if (rx_frame.len < MIN_FRAME) begin
                s_nxt.keep = fwd_undersized_good; // see R6
                s_nxt.drop = !fwd_undersized_good; // see R7
            end else begin
                s_nxt.keep = 1'b1;
            end
        end
        case (s_r.rxst)
            RX_STOPPED: begin
                if (sr) begin
                    s_nxt.rxst = RX_FETCH; // see R13
                    if (s_r.fresh) begin
                        s_nxt.curpos = s_r.rxbase; // see R13
                    end
                    s_nxt.fresh = 1'b0;
                end
            end
            RX_FETCH: begin
                if (desc_ack) begin
                    if (desc_own) begin
                        s_nxt.rxst = RX_RUNNING;
                        s_nxt.nextpos = desc_next;
                    end else begin
                        s_nxt.rxst = RX_SUSPENDED; // see R14
                        s_nxt.status[B_RBU] = 1'b1; // see R14
                    end
                end
            end
            RX_RUNNING: begin
                if (!sr) begin
                    s_nxt.rxst = RX_STOPPED; // see R17
                    s_nxt.status[B_RPS] = 1'b1;
                end else if (dma_req) begin
                    s_nxt.rxst = RX_XFER;
                end
            end
            RX_SUSPENDED: begin
                if (!sr) begin
                    s_nxt.rxst = RX_STOPPED; // see R17
                    s_nxt.status[B_RPS] = 1'b1;
                end else if (desc_poll) begin
                    s_nxt.rxst = RX_FETCH;
                end
            end
            RX_XFER: begin
                // a stop mid-frame waits here until the transfer ends
                if (xfer_done) begin
                    s_nxt.curpos = s_r.nextpos; // see R16
                    if (!sr) begin
                        s_nxt.rxst = RX_STOPPED; // see R16
                        s_nxt.status[B_RPS] = 1'b1;
                    end else begin
                        s_nxt.rxst = RX_FETCH;
                    end
                end
            end
            default: s_nxt.rxst = RX_STOPPED;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_r <= '{opmode: OPMODE_RST, status: WORD_RST, mask: WORD_RST,
                     rxbase: WORD_RST, curpos: WORD_RST, nextpos: WORD_RST,
                     rdata: WORD_RST, fresh: 1'b1, handed: 1'b0, fc_on: 1'b0,
                     drop: 1'b0, keep: 1'b0, rxst: RX_STOPPED};
        end else begin
            s_r <= s_nxt;
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    property p_fc;
        @(posedge ref_clk) disable iff (!rstn)
        (s_r.opmode[B_HWFC] && fifo_fill >= FC_ON_LVL) |=> flow_ctrl;
    endproperty
    a_fc: assert property (p_fc) else $error("flow control wrong"); // see R1

    property p_fc_off;
        @(posedge ref_clk) disable iff (!rstn)
        !s_r.opmode[B_HWFC] |=> !flow_ctrl;
    endproperty
    a_fc_off: assert property (p_fc_off) else $error("flow control while off"); // see R1

    property p_err_drop;
        @(posedge ref_clk) disable iff (!rstn)
        (rx_eof && err && !fef && !s_r.handed && !rx_frame.part_ovf) |=>
        (frame_drop && !frame_keep);
    endproperty
    a_err_drop: assert property (p_err_drop) else $error("error frame kept"); // see R2

    property p_handed;
        @(posedge ref_clk) disable iff (!rstn)
        (rx_eof && s_r.handed && !rx_frame.part_ovf) |=> frame_keep;
    endproperty
    a_handed: assert property (p_handed) else $error("handed frame dropped"); // see R3

    property p_fef;
        @(posedge ref_clk) disable iff (!rstn)
        (rx_eof && fef && !rx_frame.runt && !rx_frame.part_ovf) |=> frame_keep;
    endproperty
    a_fef: assert property (p_fef) else $error("forwarded frame dropped"); // see R4

    property p_ovf;
        @(posedge ref_clk) disable iff (!rstn)
        (rx_eof && rx_frame.part_ovf) |=> (frame_drop && !frame_keep);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflowed frame kept"); // see R5

    property p_under;
        @(posedge ref_clk) disable iff (!rstn)
        (rx_eof && !err && !rx_frame.runt && !rx_frame.part_ovf && !s_r.handed &&
         rx_frame.len < MIN_FRAME) |=> (frame_keep == $past(fwd_undersized_good));
    endproperty
    a_under: assert property (p_under) else $error("undersized handling wrong"); // see R6

    property p_short_drop;
        @(posedge ref_clk) disable iff (!rstn)
        (rx_eof && !err && !rx_frame.runt && !rx_frame.part_ovf && !s_r.handed && !fwd_undersized_good &&
         rx_frame.len < MIN_FRAME) |=> frame_drop;
    endproperty
    a_short_drop: assert property (p_short_drop) else $error("short frame kept"); // see R7

    property p_thr;
        @(posedge ref_clk) disable iff (!rstn)
        (dma_act && !rx_store_forward && s_r.opmode[B_RTC+:2] == 2'b10 && !rx_full_frame) |->
        (dma_req == (rx_bytes > 16'h0060));
    endproperty
    a_thr: assert property (p_thr) else $error("threshold 96 wrong"); // see R9

    property p_thr32;
        @(posedge ref_clk) disable iff (!rstn)
        (dma_act && !rx_store_forward && s_r.opmode[B_RTC+:2] == 2'b01 && !rx_full_frame) |->
        (dma_req == (rx_bytes > 16'h0020));
    endproperty
    a_thr32: assert property (p_thr32) else $error("threshold 32 wrong"); // see R9

    property p_rsf;
        @(posedge ref_clk) disable iff (!rstn)
        (rx_store_forward && !rx_full_frame) |-> !dma_req;
    endproperty
    a_rsf: assert property (p_rsf) else $error("threshold used in sf mode"); // see R11

    property p_osf;
        @(posedge ref_clk) disable iff (!rstn)
        (tx_frame_ready && tx_status_pending) |-> (tx_start_ok == s_r.opmode[B_OSF]);
    endproperty
    a_osf: assert property (p_osf) else $error("second frame gate wrong"); // see R12

    property p_start;
        @(posedge ref_clk) disable iff (!rstn)
        (s_r.rxst == RX_STOPPED && sr) |=> desc_req;
    endproperty
    a_start: assert property (p_start) else $error("start did not fetch"); // see R13

    property p_base;
        @(posedge ref_clk) disable iff (!rstn)
        (s_r.rxst == RX_STOPPED && sr && s_r.fresh) |=> (desc_addr == $past(s_r.rxbase));
    endproperty
    a_base: assert property (p_base) else $error("fetch not from list base"); // see R13

    property p_rbu;
        @(posedge ref_clk) disable iff (!rstn)
        (desc_req && desc_ack && !desc_own) |=>
        (s_r.rxst == RX_SUSPENDED && s_r.status[B_RBU]);
    endproperty
    a_rbu: assert property (p_rbu) else $error("no suspend on empty list"); // see R14

    property p_stop_wait;
        @(posedge ref_clk) disable iff (!rstn)
        (s_r.rxst == RX_XFER && !xfer_done) |=> (s_r.rxst == RX_XFER);
    endproperty
    a_stop_wait: assert property (p_stop_wait) else $error("left frame early"); // see R16

    property p_next_pos;
        @(posedge ref_clk) disable iff (!rstn)
        (s_r.rxst == RX_XFER && xfer_done) |=> (desc_addr == $past(s_r.nextpos));
    endproperty
    a_next_pos: assert property (p_next_pos) else $error("next position lost"); // see R16

    property p_stop;
        @(posedge ref_clk) disable iff (!rstn)
        (s_r.rxst == RX_RUNNING && !sr) |=> !rx_running;
    endproperty
    a_stop: assert property (p_stop) else $error("stop ignored while running"); // see R17

    property p_rsvd;
        @(posedge ref_clk) disable iff (!rstn)
        (reg_rd && reg_addr == OFS_OPMODE) |=> (reg_rdata[5] == 1'b0 && reg_rdata[0] == 1'b0);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set"); // see R18

    c_start: cover property (@(posedge ref_clk) disable iff (!rstn)
        s_r.rxst == RX_STOPPED ##1 s_r.rxst == RX_FETCH ##[1:20] s_r.rxst == RX_RUNNING);
    c_susp: cover property (@(posedge ref_clk) disable iff (!rstn)
        s_r.rxst == RX_SUSPENDED ##[1:20] s_r.rxst == RX_FETCH);
    c_xfer: cover property (@(posedge ref_clk) disable iff (!rstn)
        s_r.rxst == RX_XFER ##[1:50] s_r.rxst == RX_STOPPED);
    c_fc: cover property (@(posedge ref_clk) disable iff (!rstn)
        flow_ctrl ##[1:50] !flow_ctrl);
    c_handed: cover property (@(posedge ref_clk) disable iff (!rstn)
        s_r.handed && rx_eof ##1 frame_keep);
endmodule
`default_nettype wire

// ===== erx_opmode_ctrl_tb_top.sv
// self-checking bench of the rx operation-mode control block
// assumes erx_pkg, the design and the descriptor model are compiled first
`timescale 1ns/1ps
`default_nettype none
module erx_opmode_ctrl_tb_top;
    import erx_pkg::*;
    localparam logic [11:0] FC_ON = 12'hC00;
    localparam logic [11:0] FC_OFF = 12'h800;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [11:0] fifo_fill = 12'h000;
    logic rx_sof = 1'b0;
    logic [15:0] rx_bytes = 16'h0;
    logic rx_full_frame = 1'b0;
    logic rx_eof = 1'b0;
    erx_frame_s rx_frame = '0;
    logic desc_poll = 1'b0;
    logic tx_frame_ready = 1'b0;
    logic tx_status_pending = 1'b0;
    logic own_cfg = 1'b1;
    logic [31:0] reg_rdata, desc_addr, desc_next;
    logic irq, frame_drop, frame_keep, flow_ctrl, dma_req, desc_req, rx_running;
    logic tx_start_ok, desc_ack, desc_own, xfer_done;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    erx_opmode_ctrl #(.FILL_W(12), .FC_ON_LVL(FC_ON), .FC_OFF_LVL(FC_OFF)) u_erx_opmode_ctrl (
        .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .fifo_fill(fifo_fill), .rx_sof(rx_sof), .rx_bytes(rx_bytes),
        .rx_full_frame(rx_full_frame), .rx_eof(rx_eof), .rx_frame(rx_frame),
        .frame_drop(frame_drop), .frame_keep(frame_keep), .flow_ctrl(flow_ctrl),
        .dma_req(dma_req), .desc_req(desc_req), .desc_addr(desc_addr), .desc_ack(desc_ack),
        .desc_own(desc_own), .desc_next(desc_next), .desc_poll(desc_poll),
        .xfer_done(xfer_done), .rx_running(rx_running), .tx_frame_ready(tx_frame_ready),
        .tx_status_pending(tx_status_pending), .tx_start_ok(tx_start_ok));
    erx_desc_model u_erx_desc_model (
        .ref_clk(ref_clk), .rstn(rstn), .desc_req(desc_req), .desc_addr(desc_addr),
        .own_cfg(own_cfg), .desc_ack(desc_ack), .desc_own(desc_own), .desc_next(desc_next),
        .dma_req(dma_req), .xfer_done(xfer_done));
    // --------------------------------------------------------------
    // clock, timeout and shared tasks
    // --------------------------------------------------------------
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", reg_rdata, exp);
    endtask
    // bounded wait on rx_running (sel 0) or irq (sel 1)
    task automatic wait_on(input bit sel, input logic v);
        for (int n = 0; n < 50 && (sel ? irq : rx_running) !== v; n++) begin
            @(posedge ref_clk);
            #1;
        end
        check(sel ? "irq" : "rx_running", sel ? irq : rx_running, v);
    endtask
    task automatic req(input logic [15:0] b, input logic full, input logic e);
        @(posedge ref_clk);
        rx_bytes <= b;
        rx_full_frame <= full;
        #1;
        check("dma_req", dma_req, e);
    endtask
    // fl: crc,collision,rx_err,giant,watchdog,overflow,runt,part_ovf
    task automatic frame(input logic [7:0] fl, input logic [15:0] len, input logic [15:0] pre,
                         input logic exp);
        @(posedge ref_clk);
        rx_sof <= 1'b1;
        @(posedge ref_clk);
        rx_sof <= 1'b0;
        if (pre != 16'h0) begin
            rx_bytes <= pre;
            @(posedge ref_clk);
            rx_bytes <= 16'h0;
            wait_on(0, 1'b0);
            wait_on(0, 1'b1);
        end
        @(posedge ref_clk);
        rx_eof <= 1'b1;
        rx_frame <= {fl, len};
        @(posedge ref_clk);
        rx_eof <= 1'b0;
        #1;
        check("frame_keep", frame_keep, exp);
        check("frame_drop", frame_drop, !exp);
    endtask
    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] ofs [6] = '{OFS_OPMODE, OFS_STATUS, OFS_MASK, OFS_RXBASE, OFS_CURPOS, 8'h14};
        foreach (ofs[i]) rd(ofs[i], 32'h0);
        wr(OFS_OPMODE, 32'hFFFF_FFFD);
        rd(OFS_OPMODE, 32'h0200_01DC);
        wr(8'h14, 32'hFFFF_FFFF);
        wr(OFS_CURPOS, 32'hFFFF_FFFF);
        rd(8'h14, 32'h0);
        rd(OFS_CURPOS, 32'h0);
        wr(OFS_OPMODE, 32'h0);
    endtask
    task automatic t_flow();
        logic [11:0] lv [4] = '{FC_ON, FC_ON, FC_OFF, FC_OFF - 12'h1};
        logic [31:0] md [4] = '{32'h0, 32'h100, 32'h100, 32'h100};
        logic ex [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        foreach (lv[i]) begin
            fifo_fill <= lv[i];
            wr(OFS_OPMODE, md[i]);
            @(posedge ref_clk);
            #1;
            check("flow_ctrl", flow_ctrl, ex[i]);
        end
        wr(OFS_OPMODE, 32'h0);
    endtask
    task automatic t_filter();
        for (int i = 0; i < 6; i++) begin
            wr(OFS_OPMODE, 32'h0);
            frame(8'h80 >> i, 16'h0100, 16'h0, 1'b0);
            wr(OFS_OPMODE, 32'h80);
            frame(8'h80 >> i, 16'h0100, 16'h0, 1'b1);
        end
        frame(8'h02, 16'h0020, 16'h0, 1'b0);
        frame(8'h01, 16'h0100, 16'h0, 1'b0);
        wr(OFS_OPMODE, 32'h0);
        frame(8'h00, 16'h003F, 16'h0, 1'b0);
        frame(8'h00, 16'h0040, 16'h0, 1'b1);
        wr(OFS_OPMODE, 32'h40);
        frame(8'h00, 16'h003F, 16'h0, 1'b1);
    endtask
    task automatic t_dma();
        logic [15:0] thr [4] = '{16'h0040, 16'h0020, 16'h0060, 16'h0080};
        wr(OFS_MASK, 32'h0);
        wr(OFS_RXBASE, 32'h0000_1000);
        wr(OFS_OPMODE, 32'h2);
        @(posedge ref_clk);
        #1;
        check("desc_addr", desc_addr, 32'h0000_1000);
        wait_on(0, 1'b1);
        // fifo assumed larger than 128 bytes, so code 11 is legal here
        for (int c = 0; c < 4; c++) begin
            wr(OFS_OPMODE, 32'h2 | (c << 3));
            req(thr[c], 1'b0, 1'b0);
            req(thr[c] + 16'h1, 1'b0, 1'b1);
            req(16'h0, 1'b0, 1'b0);
            wait_on(0, 1'b0);
            wait_on(0, 1'b1);
        end
        wr(OFS_OPMODE, 32'h0200_001A);
        req(16'h00FF, 1'b0, 1'b0);
        req(16'h0010, 1'b1, 1'b1);
        req(16'h0, 1'b0, 1'b0);
        wait_on(0, 1'b0);
        wait_on(0, 1'b1);
        wr(OFS_OPMODE, 32'h0000_000A);
        frame(8'h80, 16'h0100, 16'h0021, 1'b1);
        frame(8'h00, 16'h0030, 16'h0021, 1'b1);
        wr(OFS_OPMODE, 32'h0);
        wait_on(0, 1'b0);
        check("irq", irq, 1'b0);
        rd(OFS_CURPOS, 32'h0000_1070);
        wr(OFS_MASK, 32'h180);
        wait_on(1, 1'b1);
        rd(OFS_STATUS, 32'h100);
        wait_on(1, 1'b0);
        own_cfg <= 1'b0;
        wr(OFS_OPMODE, 32'h2);
        @(posedge ref_clk);
        #1;
        check("desc_addr", desc_addr, 32'h0000_1070);
        wait_on(1, 1'b1);
        check("rx_running", rx_running, 1'b0);
        rd(OFS_STATUS, 32'h080);
        @(posedge ref_clk);
        desc_poll <= 1'b1;
        @(posedge ref_clk);
        desc_poll <= 1'b0;
        wait_on(1, 1'b1);
        rd(OFS_STATUS, 32'h080);
        wr(OFS_OPMODE, 32'h0);
        #1;
        check("desc_req", desc_req, 1'b0);
        wait_on(1, 1'b1);
        rd(OFS_STATUS, 32'h100);
    endtask
    task automatic t_tx();
        tx_frame_ready <= 1'b1;
        tx_status_pending <= 1'b1;
        wr(OFS_OPMODE, 32'h0);
        #1;
        check("tx_start_ok", tx_start_ok, 1'b0);
        wr(OFS_OPMODE, 32'h4);
        #1;
        check("tx_start_ok", tx_start_ok, 1'b1);
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        t_regs();
        t_flow();
        t_filter();
        t_dma();
        t_tx();
        finish_test();
    end
endmodule
`default_nettype wire

// ===== erx_pkg.sv
// constants, carriers and state codes of the rx operation-mode control block
// assumes one clock domain; all inputs come from logic on that clock
package erx_pkg;
    // --------------------------------------------------------------
    // register offsets
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_OPMODE = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_RXBASE = 8'h0C;
    localparam logic [7:0] OFS_CURPOS = 8'h10;
    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int B_SR = 1;
    localparam int B_OSF = 2;
    localparam int B_RTC = 3;
    localparam int B_FUF = 6;
    localparam int B_FEF = 7;
    localparam int B_HWFC = 8;
    localparam int B_RSF = 25;
    localparam int B_RBU = 7;
    localparam int B_RPS = 8;
    // --------------------------------------------------------------
    // reset values and masks
    // --------------------------------------------------------------
    localparam logic [31:0] OPMODE_RST = 32'h0000_0000;
    localparam logic [31:0] OPMODE_WMASK = 32'h0200_01DE;
    localparam logic [31:0] STATUS_BITS = 32'h0000_0180;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    // --------------------------------------------------------------
    // receive thresholds in bytes
    // --------------------------------------------------------------
    localparam logic [15:0] THR_C0 = 16'h0040;
    localparam logic [15:0] THR_C1 = 16'h0020;
    localparam logic [15:0] THR_C2 = 16'h0060;
    localparam logic [15:0] THR_C3 = 16'h0080;
    localparam logic [15:0] MIN_FRAME = 16'h0040;
    // --------------------------------------------------------------
    // carriers
    // --------------------------------------------------------------
    typedef struct packed {
        logic crc_err;
        logic collision;
        logic rx_err;
        logic giant;
        logic watchdog;
        logic overflow;
        logic runt;
        logic part_ovf;
        logic [15:0] len;
    } erx_frame_s;
    typedef enum logic [2:0] {
        RX_STOPPED, RX_FETCH, RX_RUNNING, RX_SUSPENDED, RX_XFER
    } erx_rxst_e;
    typedef struct packed {
        logic [31:0] opmode;
        logic [31:0] status;
        logic [31:0] mask;
        logic [31:0] rxbase;
        logic [31:0] curpos;
        logic [31:0] nextpos;
        logic [31:0] rdata;
        logic fresh;
        logic handed;
        logic fc_on;
        logic drop;
        logic keep;
        erx_rxst_e rxst;
    } erx_state_s;
endpackage
